// [inc/dba_regs.svh]
// constants of the column access block
`ifndef DBA_REGS_SVH
`define DBA_REGS_SVH
`define DBA_COL_W 6
`define DBA_DQ_W 16
`define DBA_LANE_W 8
`define DBA_PIPE_D 16
`define DBA_SYNC_STAGES 2
`define DBA_BL8_CODE 3'h3
`define DBA_BT_ILV 1'h1
`define DBA_AL_MAX 3'h4
`define DBA_CL_MIN 3'h3
`define DBA_CL_MAX 3'h6
`define DBA_PRE_CK 4'h1
`define DBA_WL_GAP 4'h1
`define DBA_PIPE_ADJ 4'h1
`define DBA_BL4_LAST 3'h3
`define DBA_BL8_LAST 3'h7
`endif

// [inc/dba_pkg.sv]
// types of the column access block
`include "dba_regs.svh"
package dba_pkg;
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_PRE = 3'b010,
    PH_DATA = 3'b100
  } dba_ph_e;
  typedef struct packed {
    logic vld;
    logic wr;
    logic bl8;
    logic ilv;
    logic [`DBA_COL_W-1:0] col;
  } dba_cmd_s;
endpackage

// [hw/dba_sync.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dba_sync #(
  parameter int W = 1
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dba_sync_s;
  dba_sync_s st_reg;
  dba_sync_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = i_d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_q = st_reg.s2;
endmodule

// [hw/dba_fifo2.sv]
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module dba_fifo2 #(
  parameter int W = 8
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  typedef struct packed {
    logic [W-1:0] d0;
    logic [W-1:0] d1;
    logic rp;
    logic [1:0] cnt;
  } dba_fifo_s;
  dba_fifo_s st_reg;
  dba_fifo_s st_next;
  logic push;
  logic pop;
  logic wp;

  assign o_ready = (st_reg.cnt != 2'h2);
  assign o_valid = (st_reg.cnt != 2'h0);
  assign o_data = st_reg.rp ? st_reg.d1 : st_reg.d0;
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;
  assign wp = st_reg.rp ^ st_reg.cnt[0];

  always_comb begin
    st_next = st_reg;
    if (push && !wp) begin
      st_next.d0 = i_data;
    end
    if (push && wp) begin
      st_next.d1 = i_data;
    end
    if (pop) begin
      st_next.rp = ~st_reg.rp;
    end
    st_next.cnt = st_reg.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// [hw/dba_column_access.sv]
// column access engine: read and write bursts with strobe and mask
//
// How it works
// - column access: cs, cas low, ras high
// - commands accepted anytime, held in the latency pipe until one clock before their data
// - read latency is additive plus cas latency
// - write latency one clock below read latency
// - cas and additive latency from mode inputs
// - burst length four or eight only
// - burst order sequential or interleaved
// - length four orders low two column bits
// - length eight: xor or nibble wrap order
// - no burst stop; bursts run full length
// - back-to-back bursts leave no gap
// - read strobe preamble one clock before data
// - read start column sampled with command
// - write decoded with we low
// - write takes full burst, ignores extra data
// - strobe single-ended or differential by mode bit
// - mask per byte, ignored on reads
// - additive latency zero to four
`timescale 1ns/1ps
`include "dba_regs.svh"
module dba_column_access #(
  parameter int DQ_W = `DBA_DQ_W,
  parameter int PIPE_D = `DBA_PIPE_D
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ck,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [`DBA_COL_W-1:0] i_addr,
  input wire logic [2:0] i_cas_lat,
  input wire logic [2:0] i_add_lat,
  input wire logic [2:0] i_burst_len,
  input wire logic i_burst_ilv,
  input wire logic i_dqs_diff_en,
  input wire logic [DQ_W-1:0] i_dq,
  output logic [DQ_W-1:0] o_dq,
  output logic o_dq_oe_n,
  input wire logic i_dqs,
  output logic o_dqs,
  output logic o_dqs_oe_n,
  output logic o_dqs_n,
  output logic o_dqs_n_oe_n,
  input wire logic [DQ_W/`DBA_LANE_W-1:0] i_dm
);
  localparam int NB = DQ_W / `DBA_LANE_W;
  localparam int CW = `DBA_COL_W;
  localparam int SW = 6 + CW + NB + DQ_W;
  localparam int FW = CW + NB + DQ_W;
  localparam int DEPTH = 1 << CW;
  localparam int PIW = $clog2(PIPE_D);

  typedef struct packed {
    logic ck_prev;
    logic dqs_prev;
    dba_pkg::dba_cmd_s [PIPE_D-1:0] pipe;
    dba_pkg::dba_ph_e rd_ph;
    dba_pkg::dba_cmd_s rd_cur;
    dba_pkg::dba_cmd_s rd_nxt;
    logic [2:0] rd_beat;
    dba_pkg::dba_ph_e wr_ph;
    dba_pkg::dba_cmd_s wr_cur;
    dba_pkg::dba_cmd_s wr_nxt;
    logic [2:0] wr_beat;
    logic [DQ_W-1:0] dq;
    logic dq_oe_n;
    logic dqs;
    logic dqs_oe_n;
    logic dqs_n;
    logic dqs_n_oe_n;
  } dba_state_s;

  dba_state_s st_reg;
  dba_state_s st_next;
  logic [DQ_W-1:0] mem [DEPTH];

  logic [SW-1:0] sync_q;
  logic ck_s;
  logic cs_n_s;
  logic ras_n_s;
  logic cas_n_s;
  logic we_n_s;
  logic dqs_s;
  logic [CW-1:0] addr_s;
  logic [NB-1:0] dm_s;
  logic [DQ_W-1:0] dq_s;
  logic ck_rise;
  logic ck_edge;
  logic dqs_rise;
  logic dqs_edge;
  logic [2:0] al_eff;
  logic [2:0] cl_eff;
  logic [3:0] rl;
  logic [3:0] slot;
  dba_pkg::dba_cmd_s new_cmd;
  dba_pkg::dba_cmd_s emerge;
  logic rd_go;
  logic wr_go;
  logic rd_end;
  logic rd_fetch;
  logic cap;
  logic [2:0] cap_beat;
  logic [FW-1:0] wb_in;
  logic wb_in_ready;
  logic wb_out_valid;
  logic [FW-1:0] wb_out;
  logic [CW-1:0] wb_col;
  logic [NB-1:0] wb_mask;
  logic [DQ_W-1:0] wb_data;

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling and edge finding

  dba_sync #(
    .W(SW)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_d({i_ck, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_dqs, i_addr, i_dm,
          i_dq}),
    .o_q(sync_q)
  );

  assign {ck_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, dqs_s, addr_s, dm_s,
          dq_s} = sync_q;
  assign ck_rise = ck_s & ~st_reg.ck_prev;
  assign ck_edge = ck_s ^ st_reg.ck_prev;
  assign dqs_rise = dqs_s & ~st_reg.dqs_prev;
  assign dqs_edge = dqs_s ^ st_reg.dqs_prev;

  ////////////////////////////////////////////////////////////////////////////
  // command decode and latency

  assign al_eff = (i_add_lat > `DBA_AL_MAX) ? `DBA_AL_MAX : i_add_lat;
  assign cl_eff = (i_cas_lat < `DBA_CL_MIN) ? `DBA_CL_MIN :
                  (i_cas_lat > `DBA_CL_MAX) ? `DBA_CL_MAX : i_cas_lat;
  assign rl = {1'b0, al_eff} + {1'b0, cl_eff};
  assign new_cmd.vld = ck_rise & ~cs_n_s & ras_n_s & ~cas_n_s;
  assign new_cmd.wr = ~we_n_s;
  assign new_cmd.bl8 = (i_burst_len == `DBA_BL8_CODE);
  assign new_cmd.ilv = (i_burst_ilv == `DBA_BT_ILV);
  assign new_cmd.col = addr_s;
  // write strobe starts one clock before the read strobe would
  assign slot = rl - `DBA_PRE_CK - `DBA_PIPE_ADJ
              - (new_cmd.wr ? `DBA_WL_GAP : 4'h0);
  assign emerge = st_reg.pipe[0];
  assign rd_go = ck_rise & emerge.vld & ~emerge.wr;
  assign wr_go = ck_rise & emerge.vld & emerge.wr;

  function automatic logic [CW-1:0] beat_col(
    input dba_pkg::dba_cmd_s c,
    input logic [2:0] k
  );
    logic [2:0] lo;
    logic [1:0] wrap;
    lo = c.col[2:0];
    wrap = lo[1:0] + k[1:0];
    if (c.ilv && c.bl8) begin
      lo = lo ^ k;
    end else if (c.ilv) begin
      lo = {lo[2], lo[1:0] ^ k[1:0]};
    end else if (c.bl8) begin
      lo = {lo[2] ^ k[2], wrap};
    end else begin
      lo = {lo[2], wrap};
    end
    return {c.col[CW-1:3], lo};
  endfunction

  function automatic logic [2:0] last_beat(input dba_pkg::dba_cmd_s c);
    return c.bl8 ? `DBA_BL8_LAST : `DBA_BL4_LAST;
  endfunction

  assign rd_end = ck_rise & (st_reg.rd_beat == last_beat(st_reg.rd_cur));

  ////////////////////////////////////////////////////////////////////////////
  // write capture path

  assign cap = ((st_reg.wr_ph == dba_pkg::PH_PRE) & dqs_rise)
             | ((st_reg.wr_ph == dba_pkg::PH_DATA) & dqs_edge);
  assign cap_beat = (st_reg.wr_ph == dba_pkg::PH_PRE) ? 3'h0
                  : st_reg.wr_beat;
  assign wb_in = {beat_col(st_reg.wr_cur, cap_beat), dm_s, dq_s};
  // array port goes to reads first, writes wait in the buffer
  assign rd_fetch = ck_edge & (st_reg.rd_ph != dba_pkg::PH_IDLE);

  dba_fifo2 #(
    .W(FW)
  ) u_wbuf (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_valid(cap),
    .o_ready(wb_in_ready),
    .i_data(wb_in),
    .o_valid(wb_out_valid),
    .i_ready(~rd_fetch),
    .o_data(wb_out)
  );

  assign {wb_col, wb_mask, wb_data} = wb_out;

  always_ff @(posedge i_mclk) begin
    if (wb_out_valid && !rd_fetch) begin
      for (int b = 0; b < NB; b++) begin
        if (!wb_mask[b]) begin
          mem[wb_col][b*`DBA_LANE_W +: `DBA_LANE_W] <=
            wb_data[b*`DBA_LANE_W +: `DBA_LANE_W];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_next = st_reg;
    st_next.ck_prev = ck_s;
    st_next.dqs_prev = dqs_s;
    // latency pipe advances once per clock rise
    if (ck_rise) begin
      for (int i = 0; i < PIPE_D - 1; i++) begin
        st_next.pipe[i] = st_reg.pipe[i+1];
      end
      st_next.pipe[PIPE_D-1] = '0;
      if (new_cmd.vld) begin
        st_next.pipe[slot[PIW-1:0]] = new_cmd;
      end
    end
    // read engine
    unique case (st_reg.rd_ph)
      dba_pkg::PH_IDLE: begin
        if (rd_go) begin
          st_next.rd_ph = dba_pkg::PH_PRE;
          st_next.rd_cur = emerge;
          st_next.dqs = 1'b0;
          st_next.dqs_oe_n = 1'b0;
        end
      end
      dba_pkg::PH_PRE: begin
        if (rd_go) begin
          st_next.rd_nxt = emerge;
        end
        if (ck_rise) begin
          st_next.rd_ph = dba_pkg::PH_DATA;
          st_next.rd_beat = 3'h0;
          st_next.dq = mem[beat_col(st_reg.rd_cur, 3'h0)];
          st_next.dq_oe_n = 1'b0;
          st_next.dqs = 1'b1;
        end
      end
      dba_pkg::PH_DATA: begin
        if (rd_go && !rd_end) begin
          st_next.rd_nxt = emerge;
        end
        if (ck_edge) begin
          if (st_reg.rd_beat != last_beat(st_reg.rd_cur)) begin
            st_next.rd_beat = st_reg.rd_beat + 3'h1;
            st_next.dq = mem[beat_col(st_reg.rd_cur,
                                      st_reg.rd_beat + 3'h1)];
            st_next.dqs = ck_s;
          end else if (st_reg.rd_nxt.vld) begin
            st_next.rd_cur = st_reg.rd_nxt;
            st_next.rd_nxt = '0;
            st_next.rd_beat = 3'h0;
            st_next.dq = mem[beat_col(st_reg.rd_nxt, 3'h0)];
            st_next.dqs = ck_s;
          end else if (rd_go) begin
            st_next.rd_ph = dba_pkg::PH_PRE;
            st_next.rd_cur = emerge;
            st_next.dq_oe_n = 1'b1;
            st_next.dqs = 1'b0;
          end else begin
            st_next.rd_ph = dba_pkg::PH_IDLE;
            st_next.dq_oe_n = 1'b1;
            st_next.dqs_oe_n = 1'b1;
            st_next.dqs = 1'b0;
          end
        end
      end
    endcase
    // write engine
    unique case (st_reg.wr_ph)
      dba_pkg::PH_IDLE: begin
        if (wr_go) begin
          st_next.wr_ph = dba_pkg::PH_PRE;
          st_next.wr_cur = emerge;
        end
      end
      dba_pkg::PH_PRE: begin
        if (wr_go) begin
          st_next.wr_nxt = emerge;
        end
        if (dqs_rise) begin
          st_next.wr_ph = dba_pkg::PH_DATA;
          st_next.wr_beat = 3'h1;
        end
      end
      dba_pkg::PH_DATA: begin
        if (wr_go) begin
          st_next.wr_nxt = emerge;
        end
        if (dqs_edge) begin
          if (st_reg.wr_beat != last_beat(st_reg.wr_cur)) begin
            st_next.wr_beat = st_reg.wr_beat + 3'h1;
          end else if (st_reg.wr_nxt.vld || wr_go) begin
            st_next.wr_ph = dba_pkg::PH_PRE;
            st_next.wr_cur = st_reg.wr_nxt.vld ? st_reg.wr_nxt : emerge;
            st_next.wr_nxt = '0;
            st_next.wr_beat = 3'h0;
          end else begin
            st_next.wr_ph = dba_pkg::PH_IDLE;
          end
        end
      end
    endcase
    st_next.dqs_n = ~st_next.dqs;
    st_next.dqs_n_oe_n = st_next.dqs_oe_n | ~i_dqs_diff_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_reg <= '0;
      st_reg.rd_ph <= dba_pkg::PH_IDLE;
      st_reg.wr_ph <= dba_pkg::PH_IDLE;
      st_reg.dq_oe_n <= 1'b1;
      st_reg.dqs_oe_n <= 1'b1;
      st_reg.dqs_n <= 1'b1;
      st_reg.dqs_n_oe_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_dq = st_reg.dq;
  assign o_dq_oe_n = st_reg.dq_oe_n;
  assign o_dqs = st_reg.dqs;
  assign o_dqs_oe_n = st_reg.dqs_oe_n;
  assign o_dqs_n = st_reg.dqs_n;
  assign o_dqs_n_oe_n = st_reg.dqs_n_oe_n;
  // write buffer refusal is unreachable at strobe rates below mclk/2
  logic unused_ready;
  assign unused_ready = wb_in_ready;
endmodule

// [verification/dba_column_access_chk.sv]
// checker: read latency, strobe shape and burst framing
`timescale 1ns/1ps
`include "dba_regs.svh"
module dba_column_access_chk (
  input logic i_mclk,
  input logic i_rst_n,
  input logic i_ck,
  input logic i_cs_n,
  input logic i_ras_n,
  input logic i_cas_n,
  input logic i_we_n,
  input logic [2:0] i_cas_lat,
  input logic [2:0] i_add_lat,
  input logic [2:0] i_burst_len,
  input logic i_dqs_diff_en,
  input logic o_dq_oe_n,
  input logic o_dqs,
  input logic o_dqs_oe_n,
  input logic o_dqs_n,
  input logic o_dqs_n_oe_n
);
  logic ck_q, dqs_q, oe_q, rd_hit;
  logic [7:0] lat;
  logic [4:0] beats;
  int rl;
  int bl;
  assign rl = 8 * (int'(i_add_lat) + int'(i_cas_lat));
  assign bl = (i_burst_len == `DBA_BL8_CODE) ? 8 : 4;
  assign rd_hit = i_ck && !ck_q && !i_cs_n && i_ras_n && !i_cas_n
    && i_we_n;
  always_ff @(posedge i_mclk) begin
    ck_q <= i_ck;
    dqs_q <= o_dqs;
    oe_q <= o_dq_oe_n;
    if (!i_rst_n) lat <= 8'hFF;
    // a seamless follow-on read keeps the count of the first
    else if (rd_hit && int'(lat) > 4 * bl + 4) lat <= 8'h00;
    else if (lat != 8'hFF) lat <= lat + 8'h01;
    if (!i_rst_n || o_dq_oe_n) beats <= 5'h00;
    else if (oe_q || o_dqs != dqs_q) beats <= beats + 5'h01;
  end
  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence pre_s;
    (o_dq_oe_n && !o_dqs && !o_dqs_oe_n) [*6];
  endsequence
  sequence first_s;
    !o_dq_oe_n && o_dqs;
  endsequence
  rd_lat_a: assert property (
    $fell(o_dq_oe_n) |-> lat >= rl && lat <= rl + 5)
    else $error("first beat off read latency");
  pre_lat_a: assert property (
    $fell(o_dqs_oe_n) |-> lat >= rl - 8 && lat <= rl - 3)
    else $error("preamble off time");
  pre_shape_a: assert property (
    $fell(o_dqs_oe_n) |-> pre_s ##[1:4] first_s)
    else $error("bad preamble");
  beat_gap_a: assert property (
    !o_dq_oe_n && $changed(o_dqs) |=>
      $stable(o_dqs) [*3] ##1 ($changed(o_dqs) || o_dq_oe_n))
    else $error("beat not half a clock");
  release_a: assert property (
    $rose(o_dq_oe_n) |-> $rose(o_dqs_oe_n) && !o_dqs)
    else $error("bus not released together");
  burst_cnt_a: assert property (
    $rose(o_dq_oe_n) |-> beats == bl || beats == 2 * bl)
    else $error("wrong beat count");
  dqs_n_en_a: assert property (
    $stable(i_dqs_diff_en) |->
      o_dqs_n_oe_n == (o_dqs_oe_n || !i_dqs_diff_en))
    else $error("complement strobe enable wrong");
  dqs_n_inv_a: assert property (
    !o_dqs_n_oe_n |-> o_dqs_n == !o_dqs)
    else $error("complement strobe not inverse");
endmodule

// [verification/dba_ctrl_model.sv]
// controller model: clock, commands, write strobe and data
`timescale 1ns/1ps
module dba_ctrl_model (
  output logic o_ck,
  output logic o_cs_n,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n,
  output logic [5:0] o_addr,
  output logic [15:0] o_dq,
  output logic [1:0] o_dm,
  output logic o_dqs
);
  initial begin
    {o_ck, o_dqs, o_dq, o_dm, o_addr} = '0;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hF;
    #7;
    forever #80 o_ck = ~o_ck;
  end
  //////////////////////////////////////////////////////////////////////
  // no precharge is ever issued
  task automatic cmd(input logic [2:0] rcw, input logic [5:0] a);
    @(negedge o_ck);
    o_cs_n = 1'b0;
    {o_ras_n, o_cas_n, o_we_n} = rcw;
    o_addr = a;
    @(negedge o_ck);
    o_cs_n = 1'b1;
    {o_ras_n, o_cas_n, o_we_n} = 3'h7;
    o_addr = ~a;
  endtask
  task automatic wr(input logic [5:0] a, input int wl, input int bl,
    input logic [15:0] d [8], input logic [1:0] m [8]);
    cmd(3'h4, a);
    repeat (wl - 2) @(negedge o_ck);
    @(posedge o_ck);
    o_dqs = 1'b0; // preamble one clock before write latency
    for (int k = 0; k < bl + 2; k++) begin
      #40;
      o_dq = (k < bl) ? d[k] : ~o_dq; // beats past burst
      o_dm = (k < bl) ? m[k] : 2'h0;
      if (k % 2 == 0) @(posedge o_ck);
      else @(negedge o_ck);
      o_dqs = ~o_dqs; // first rise at write latency
    end
    @(posedge o_ck);
    o_dq = ~o_dq;
    o_dqs = ~o_dqs;
    o_dm = 2'h3; // mask held high over reads
  endtask
endmodule

// [verification/ddr2_burst_read_write_access_tb_top.sv]
// bench: burst writes and reads against a reference array
`timescale 1ns/1ps
module ddr2_burst_read_write_access_tb_top;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic ilv = 1'b0;
  logic diff_en = 1'b0;
  logic dqs_p = 1'b0;
  logic oe_p = 1'b1;
  int al = 0;
  int cl = 3;
  int bl = 8;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  logic ck, cs_n, ras_n, cas_n, we_n, m_dqs, dq_oe_n, dqs, dqs_oe_n, dqs_w;
  logic [5:0] addr;
  logic [1:0] m_dm;
  logic [15:0] m_dq, dq, dq_w;
  logic [15:0] ref_mem [64];
  logic [15:0] rq [$];
  logic [15:0] eq [$];
  assign dq_w = dq_oe_n ? m_dq : dq;
  assign dqs_w = dqs_oe_n ? m_dqs : dqs;
  always #10 i_mclk = ~i_mclk;
  dba_ctrl_model m_u (.o_ck(ck), .o_cs_n(cs_n), .o_ras_n(ras_n),
    .o_cas_n(cas_n), .o_we_n(we_n), .o_addr(addr), .o_dq(m_dq),
    .o_dm(m_dm), .o_dqs(m_dqs));
  dba_column_access dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ck(ck),
    .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n),
    .i_addr(addr), .i_cas_lat(3'(cl)), .i_add_lat(3'(al)),
    .i_burst_len(bl == 8 ? 3'h3 : 3'h2), .i_burst_ilv(ilv),
    .i_dqs_diff_en(diff_en), .i_dq(dq_w), .o_dq(dq), .o_dq_oe_n(dq_oe_n),
    .i_dqs(dqs_w), .o_dqs(dqs), .o_dqs_oe_n(dqs_oe_n), .o_dqs_n(),
    .o_dqs_n_oe_n(), .i_dm(m_dm));
  //////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] col_of(input logic [5:0] s, input int k);
    logic [2:0] o;
    o = ilv ? s[2:0] ^ 3'(k) : {s[2] ^ (k > 3), s[1:0] + 2'(k)};
    return {s[5:3], o};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cfg(input int a, input int c, input int b,
    input logic i, input logic d);
    @(negedge i_mclk);
    al = a;
    cl = c;
    bl = b;
    ilv = i;
    diff_en = d;
  endtask
  task automatic wr(input logic [5:0] s, input logic [7:0] sd,
    input logic [1:0] mk);
    logic [15:0] d [8];
    logic [1:0] m [8];
    logic [5:0] c;
    for (int k = 0; k < 8; k++) begin
      d[k] = {sd, 8'(k) ^ sd};
      m[k] = (k % 2 == 1) ? mk : 2'h0;
      c = col_of(s, k);
      if (k < bl && !m[k][0]) ref_mem[c][7:0] = d[k][7:0];
      if (k < bl && !m[k][1]) ref_mem[c][15:8] = d[k][15:8];
    end
    m_u.wr(s, al + cl - 1, bl, d, m);
  endtask
  task automatic rd(input logic [5:0] s);
    m_u.cmd(3'h5, s);
    for (int k = 0; k < bl; k++) eq.push_back(ref_mem[col_of(s, k)]);
  endtask
  task automatic drain(input string name);
    repeat (al + cl + 6) @(posedge ck);
    chk(16'(rq.size()), 16'(eq.size()));
    while (eq.size() > 0 && rq.size() > 0) begin
      chk(rq.pop_front(), eq.pop_front());
    end
    rq.delete();
    eq.delete();
    $display("test %s done", name);
  endtask
  //////////////////////////////////////////////////////////////////////
  always @(negedge i_mclk) begin
    if (!dq_oe_n && (oe_p || dqs != dqs_p)) rq.push_back(dq);
    dqs_p = dqs;
    oe_p = dq_oe_n;
    cyc++;
    if (cyc == 10000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    repeat (10) @(negedge i_mclk);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_mclk);
    m_u.cmd(3'h3, 6'h00); // bank opened first
    wr(6'h08, 8'hA1, 2'h0);
    wr(6'h15, 8'hB2, 2'h0);
    rd(6'h0D);
    drain("bl8_seq");
    cfg(0, 3, 8, 1'b1, 1'b1);
    wr(6'h13, 8'hC3, 2'h1);
    rd(6'h16); // mask high during read
    drain("bl8_ilv");
    for (int i = 0; i < 2; i++) begin
      cfg(0, 3, 4, i[0], 1'b0);
      wr(6'h1A, 8'hD4 + 8'(i), 2'h2);
      rd(6'h0B);
      rd(6'h19); // seamless pair
      drain("bl4_pair");
    end
    cfg(4, 6, 4, 1'b0, 1'b1);
    m_u.cmd(3'h3, 6'h00); // column right after open
    wr(6'h0E, 8'hE5, 2'h0);
    rd(6'h0F);
    drain("posted");
    end_of_test();
  end
endmodule
bind dba_column_access dba_column_access_chk chk_u (.*);
